//--- rtl/ebsc_ctrl.sv
// bus master signal control: burst, cycle type, write/read, data strobe,
// reservation cancel and reset output; bus pins are sampled on clk
`timescale 1ns/1ns
`include "ebsc_params.svh"

// Summary of operation
// - every bus output changes on the rising clock edge, except the reset output, which drops at once with rst_n, and the bus clock, which is clk.
// - an asserted cancel-reservation input clears the pending reservation.
// - the data strobe pulses when a chip-select cycle ends by internal ack or bus-monitor error.
// - the data strobe also pulses at the end of each show cycle.
// - the reset output stays asserted while the device is in reset.
// - the hard reset input puts the device and all bus devices into reset.
// - burst is asserted for burst cycles and negated for single beats.
// - a four-bit cycle-type code goes out with each cycle started.
// - write/read is low for write and high for read.
module ebsc_ctrl
    import ebsc_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // bus clock and reset outputs
    output logic                      bus_clock_output,
    output logic                      reset_output_n,
    // internal request side
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire logic                 req_write,
    input  wire logic                 req_burst,
    input  wire logic [`EBSC_CT_W-1:0] req_cycle_type,
    input  wire logic                 req_cs_ctrl,
    input  wire logic                 req_show,
    input  wire logic                 set_reservation,
    input  wire logic                 cs_internal_ack,
    input  wire logic                 bmt_internal_err,
    output logic                      done_pulse,
    output logic                      done_error,
    output logic                      reservation_held,
    // external bus pins
    input  wire logic                 transfer_ack_n,
    input  wire logic                 transfer_error_ack_n,
    input  wire logic                 cancel_reservation_in_n,
    output logic                      burst_n,
    output logic [`EBSC_CT_W-1:0]     cycle_type_code,
    output logic                      write_read,
    output logic                      data_strobe_out_n
);
    ebsc_state_t       state_reg, state_next;
    logic              ta_m_reg, ta_s_reg, tea_m_reg, tea_s_reg, cr_m_reg, cr_s_reg;
    logic              burst_reg, burst_next, wr_reg, wr_next;
    logic [`EBSC_CT_W-1:0] ct_reg, ct_next;
    logic              cs_reg, cs_next, show_reg, show_next;
    logic              ds_reg, ds_next, done_reg, done_next, err_reg, err_next;
    logic              resv_reg, resv_next;
    logic [3:0]        rcnt_reg, rcnt_next;
    logic              ta_hit, tea_hit, end_now;

    // two-flop synchronisers for pins from the far side
    always_ff @(posedge clk)
    begin
        ta_m_reg  <= transfer_ack_n;
        ta_s_reg  <= ta_m_reg;
        tea_m_reg <= transfer_error_ack_n;
        tea_s_reg <= tea_m_reg;
        cr_m_reg  <= cancel_reservation_in_n;
        cr_s_reg  <= cr_m_reg;
    end

    assign ta_hit  = !ta_s_reg || (cs_reg && cs_internal_ack);
    assign tea_hit = !tea_s_reg || (cs_reg && bmt_internal_err);
    assign end_now = (state_reg == EBSC_DATA) && (ta_hit || tea_hit || show_reg);
    assign req_ready = (state_reg == EBSC_IDLE);

    always_comb
    begin
        state_next = state_reg;
        burst_next = burst_reg;
        wr_next    = wr_reg;
        ct_next    = ct_reg;
        cs_next    = cs_reg;
        show_next  = show_reg;
        ds_next    = 1'b0;
        done_next  = 1'b0;
        err_next   = err_reg;
        resv_next  = resv_reg;
        rcnt_next  = (rcnt_reg != 4'h0) ? rcnt_reg - 4'h1 : 4'h0;
        if (set_reservation)
            resv_next = 1'b1;
        if (!cr_s_reg)
            resv_next = 1'b0;
        unique case (state_reg)
            EBSC_IDLE:
            begin
                if (req_valid)
                begin
                    burst_next = req_burst;
                    ct_next    = req_cycle_type;
                    wr_next    = !req_write;
                    cs_next    = req_cs_ctrl;
                    show_next  = req_show;
                    state_next = EBSC_ADDR;
                end
            end
            EBSC_ADDR:
                state_next = EBSC_DATA;
            EBSC_DATA:
            begin
                if (end_now)
                begin
                    ds_next    = cs_reg || show_reg;
                    done_next  = 1'b1;
                    err_next   = tea_hit && !show_reg;
                    burst_next = 1'b0;
                    ct_next    = `EBSC_CT_IDLE;
                    state_next = EBSC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_reg <= EBSC_IDLE;
            burst_reg <= 1'b0;
            wr_reg    <= 1'b1;
            ct_reg    <= `EBSC_CT_IDLE;
            cs_reg    <= 1'b0;
            show_reg  <= 1'b0;
            ds_reg    <= 1'b0;
            done_reg  <= 1'b0;
            err_reg   <= 1'b0;
            resv_reg  <= 1'b0;
            rcnt_reg  <= `EBSC_RST_STRETCH;
        end
        else
        begin
            state_reg <= state_next;
            burst_reg <= burst_next;
            wr_reg    <= wr_next;
            ct_reg    <= ct_next;
            cs_reg    <= cs_next;
            show_reg  <= show_next;
            ds_reg    <= ds_next;
            done_reg  <= done_next;
            err_reg   <= err_next;
            resv_reg  <= resv_next;
            rcnt_reg  <= rcnt_next;
        end
    end

    // bus clock is the core clock
    // a divided copy would add skew between pins and their sampling edge
    assign bus_clock_output = clk;

    assign reset_output_n    = rst_n && (rcnt_reg == 4'h0);
    assign burst_n           = !burst_reg;
    assign cycle_type_code   = ct_reg;
    assign write_read        = wr_reg;
    assign data_strobe_out_n = !ds_reg;
    assign done_pulse        = done_reg;
    assign done_error        = err_reg;
    assign reservation_held  = resv_reg;

    // assertions
    AST_RESET_OUT: assert property (@(posedge clk) !rst_n |=> !reset_output_n)
        else $error("reset output released during reset");
    AST_RESET_STRETCH: assert property (@(posedge clk) $rose(rst_n) |-> !reset_output_n[*4])
        else $error("reset output not stretched");
    AST_CANCEL: assert property (@(posedge clk) disable iff (!rst_n)
        !cr_s_reg |=> !reservation_held)
        else $error("reservation survived cancel");
    AST_SET: assert property (@(posedge clk) disable iff (!rst_n)
        (set_reservation && cr_s_reg) |=> reservation_held)
        else $error("reservation not set");
    AST_DS_CS: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == EBSC_DATA && cs_reg && ta_hit) |=> !data_strobe_out_n)
        else $error("no strobe at chip-select end");
    AST_DS_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        !data_strobe_out_n |=> data_strobe_out_n)
        else $error("data strobe longer than one cycle");
    AST_DS_SHOW: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == EBSC_DATA && show_reg) |=> !data_strobe_out_n ##1 data_strobe_out_n)
        else $error("show cycle strobe wrong");
    AST_DONE_TA: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == EBSC_DATA && !ta_s_reg) |=> done_pulse)
        else $error("ack did not complete transfer");
    AST_ERR_TEA: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == EBSC_DATA && !tea_s_reg && !show_reg) |=> done_pulse && done_error)
        else $error("error ack not reported");
    AST_BURST: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_ready) |=> (burst_n == !$past(req_burst)))
        else $error("burst output mismatch");
    AST_BURST_END: assert property (@(posedge clk) disable iff (!rst_n)
        done_pulse |-> burst_n)
        else $error("burst still asserted after cycle end");
    AST_CT: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_ready) |=> (cycle_type_code == $past(req_cycle_type)))
        else $error("cycle type mismatch");
    AST_CT_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == EBSC_IDLE) |-> (cycle_type_code == `EBSC_CT_IDLE))
        else $error("cycle type driven while idle");
    AST_WR: assert property (@(posedge clk) disable iff (!rst_n)
        (req_valid && req_ready) |=> (write_read == !$past(req_write)))
        else $error("write/read polarity wrong");
    AST_CLK_LOW: assert property (@(posedge clk) !bus_clock_output)
        else $error("bus clock low phase missing");
    AST_CLK_HIGH: assert property (@(negedge clk) bus_clock_output)
        else $error("bus clock high phase missing");

    COV_CS_END: cover property (@(posedge clk) !data_strobe_out_n && cs_reg);
    COV_SHOW: cover property (@(posedge clk) !data_strobe_out_n && show_reg);
    COV_ERR: cover property (@(posedge clk) done_pulse && done_error);
    COV_BURST: cover property (@(posedge clk) !burst_n && !write_read);
endmodule

//--- rtl/ebsc_params.svh
// constants for the external bus signal control block
// assumes a 100 MHz core clock shared with the bus clock output
`ifndef EBSC_PARAMS_SVH
`define EBSC_PARAMS_SVH
`define EBSC_CT_W          4
`define EBSC_CT_IDLE       4'h0
`define EBSC_RST_STRETCH   4'h4
`define EBSC_DS_CYCLES     1
`endif

//--- rtl/ebsc_pkg.sv
// types for the external bus signal control block
// used by ebsc_ctrl only
`include "ebsc_params.svh"
package ebsc_pkg;
    typedef enum logic [1:0] {EBSC_IDLE, EBSC_ADDR, EBSC_DATA} ebsc_state_t;
endpackage

//--- bench/ebsc_slave_model.sv
// slave model: answers each started bus cycle once, promptly or slowly, except in silent mode, where it never answers
// assumes a nonzero cycle type code while a cycle is on the bus
`timescale 1ns/1ns
`include "ebsc_params.svh"
module ebsc_slave_model (
    // clock, reset and answer mode (0 slow ack, 1 error, 2 silent, 3 prompt ack)
    input  wire logic                  clk,
    input  wire logic                  reset_output_n,
    input  wire logic [1:0]            mode,
    // bus pins
    input  wire logic [`EBSC_CT_W-1:0] cycle_type_code,
    output logic                       transfer_ack_n,
    output logic                       transfer_error_ack_n
);
    logic       answered;
    logic       hit;
    logic [1:0] wait_cnt;
    initial {transfer_ack_n, transfer_error_ack_n} = 2'b11;
    // answer due at this edge: prompt mode at once, slow ack and error modes after two waits
    assign hit = reset_output_n && cycle_type_code != 4'h0 && !answered && mode != 2'h2
                 && (mode == 2'h3 || wait_cnt == 2'h2);
    // one-cycle answer on the rising edge, then back to pull-up level
    always @(posedge clk)
    begin
        transfer_ack_n       <= !(hit && mode != 2'h1);
        transfer_error_ack_n <= !(hit && mode == 2'h1);
        if (!reset_output_n || cycle_type_code == 4'h0)
        begin
            wait_cnt <= 2'h0;
            answered <= 1'b0;
        end
        else if (!answered && mode != 2'h2)
        begin
            wait_cnt <= wait_cnt + 2'h1;
            answered <= hit;
        end
    end
endmodule

//--- bench/ebsc_ctrl_tb.sv
// self-checking bench for the bus signal control block
// assumes the slave model answers on the external pins
`timescale 1ns/1ns
`include "ebsc_params.svh"
module ebsc_ctrl_tb;
    logic       clk = 0, rst_n = 0, req_valid = 0, req_write = 0, req_burst = 0;
    logic       req_cs_ctrl = 0, req_show = 0, set_reservation = 0, cs_internal_ack = 0;
    logic       bmt_internal_err = 0, cancel_reservation_in_n = 1;
    logic [3:0] req_cycle_type = 4'h1, cycle_type_code;
    logic [1:0] mode = 2'h0;
    logic       bus_clock_output, reset_output_n, req_ready, done_pulse, done_error;
    logic       reservation_held, transfer_ack_n, transfer_error_ack_n, burst_n;
    logic       write_read, data_strobe_out_n;
    int         n_errors = 0, checks_done = 0;
    always #5 clk = ~clk;
    ebsc_ctrl ebsc_ctrl_inst (.clk, .rst_n, .bus_clock_output, .reset_output_n, .req_valid,
        .req_ready, .req_write, .req_burst, .req_cycle_type, .req_cs_ctrl, .req_show,
        .set_reservation, .cs_internal_ack, .bmt_internal_err, .done_pulse, .done_error,
        .reservation_held, .transfer_ack_n, .transfer_error_ack_n, .cancel_reservation_in_n,
        .burst_n, .cycle_type_code, .write_read, .data_strobe_out_n);
    ebsc_slave_model ebsc_slave_model_inst (.clk, .reset_output_n, .mode, .cycle_type_code,
        .transfer_ack_n, .transfer_error_ack_n);
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus_cycle(input logic w, b, cs, sh, err, input logic [3:0] ct,
                             input logic [1:0] m);
        int n;
        {req_write, req_burst, req_cs_ctrl, req_show, req_cycle_type, mode} = {w, b, cs, sh, ct, m};
        {cs_internal_ack, bmt_internal_err} = {cs && !err, cs && err};
        req_valid = 1;
        chk({3'h0, req_ready}, 4'h1);
        tick(1);
        req_valid = 0;
        // clock high just after the edge, burst and direction during the cycle
        chk({1'b0, bus_clock_output, burst_n, write_read}, {1'b0, 1'b1, !b, !w});
        chk(cycle_type_code, ct);
        n = 0;
        while (done_pulse !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        {cs_internal_ack, bmt_internal_err} = 2'b00;
        // completion, error flag and strobe
        chk({1'b0, done_pulse, done_error, data_strobe_out_n}, {2'b01, err, !(cs || sh)});
        $display("cycle done: type %h", ct);
    endtask
    task automatic t_reset();
        int n;
        chk({reset_output_n, burst_n, write_read, data_strobe_out_n}, 4'h7);
        chk(cycle_type_code, 4'h0);
        rst_n = 1;
        n = 0;
        while (reset_output_n !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk(n[3:0], `EBSC_RST_STRETCH);
        $display("test done: reset");
    endtask
    task automatic t_cycles();
        // every nonzero code, direction, burst and answer speed via the slave
        for (int i = 1; i < 16; i++)
            bus_cycle(i[0], i[1], 0, 0, 0, i[3:0], i[2] ? 2'h3 : 2'h0);
        bus_cycle(1, 0, 0, 0, 1, 4'h5, 2'h1);
        bus_cycle(0, 1, 1, 0, 0, 4'h9, 2'h2);
        bus_cycle(1, 0, 1, 0, 1, 4'h9, 2'h2);
        bus_cycle(0, 0, 0, 1, 0, 4'hc, 2'h2);
        tick(1);
        chk({3'h0, data_strobe_out_n}, 4'h1);
        chk(cycle_type_code, `EBSC_CT_IDLE);
        $display("test done: cycles");
    endtask
    task automatic t_resv();
        set_reservation = 1;
        tick(1);
        set_reservation = 0;
        tick(1);
        chk({3'h0, reservation_held}, 4'h1);
        cancel_reservation_in_n = 0;
        tick(4);
        chk({3'h0, reservation_held}, 4'h0);
        // set while the cancel is seen: cancel wins
        set_reservation = 1;
        tick(1);
        set_reservation = 0;
        chk({3'h0, reservation_held}, 4'h0);
        cancel_reservation_in_n = 1;
        rst_n = 0;
        tick(3);
        chk({reset_output_n, burst_n, write_read, data_strobe_out_n}, 4'h7);
        rst_n = 1;
        tick(6);
        chk({3'h0, reset_output_n}, 4'h1);
        bus_cycle(0, 0, 0, 0, 0, 4'h3, 2'h3);
        $display("test done: reservation and reset");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        tick(8);
        t_reset();
        t_cycles();
        t_resv();
        print_verdict();
    end
    // watchdog well beyond the roughly 140 cycles the tests need
    initial
    begin
        #50000;
        n_errors++;
        print_verdict();
    end
endmodule
